// File: shared/amos_cfg.svh
// constants for accelerometer mode control and output scaling
// Notes on behaviour
// - Target never holds the serial clock low; no clock stretching.
// - Bus inputs ignore clock and data glitches up to 50 ns wide.
// - Output codes are 256, 128, 64 counts per g for 2, 4, 8 g.
// - Samples sit in output registers from address zero, two's complement.
// - Zero acceleration reads as code zero, middle of the signed range.
// - With self-test on, sample equals real acceleration plus test stimulus.
// - Self-test shift scales with the selected range's counts per g.
// - Run-enable clear means standby: logic on, sampling and clocks off.
// - Run-enable set means active: digital and analog sampling both on.
// - Register reads are answered in standby and in active mode.
// - Entering active from standby returns a register subset to reset values.
// - Sleep and wake are active sub-states, never entered with run-enable clear.
// - Each axis is 10-bit two's complement, split into high and low bytes.
`ifndef AMOS_CFG_SVH
`define AMOS_CFG_SVH

`define AMOS_CLK_MHZ    100
`define AMOS_SPIKE_NS   50
// longest suppressed spike, rounded down to whole cycles
`define AMOS_SPIKE_CYC  ((`AMOS_SPIKE_NS * `AMOS_CLK_MHZ) / 1000)
`define AMOS_FILT_W     4

`define AMOS_RAW_W      14
`define AMOS_OUT_W      10
`define AMOS_OUT_MAX    10'h1ff
`define AMOS_OUT_MIN    10'h200

// range select codes and right shift from 1/256 g input units
`define AMOS_RANGE_2G   2'h0
`define AMOS_RANGE_4G   2'h1
`define AMOS_RANGE_8G   2'h2
`define AMOS_SHIFT_2G   2'h0
`define AMOS_SHIFT_4G   2'h1
`define AMOS_SHIFT_8G   2'h2

// output register addresses
`define AMOS_ADDR_W     3
`define AMOS_ADDR_X_HI  3'h0
`define AMOS_ADDR_X_LO  3'h1
`define AMOS_ADDR_Y_HI  3'h2
`define AMOS_ADDR_Y_LO  3'h3
`define AMOS_ADDR_Z_HI  3'h4
`define AMOS_ADDR_Z_LO  3'h5

`endif

// File: shared/amos_pkg.sv
// types for accelerometer mode control and output scaling
`default_nettype none
`include "amos_cfg.svh"
package amos_pkg;

  typedef enum logic [1:0] {
    AMOS_STANDBY = 2'b00,
    AMOS_WAKE    = 2'b01,
    AMOS_SLEEP   = 2'b10
  } amos_mode_e;

  typedef logic signed [`AMOS_RAW_W-1:0] amos_raw_t;
  typedef logic signed [`AMOS_OUT_W-1:0] amos_code_t;

  typedef struct packed {
    amos_raw_t x;
    amos_raw_t y;
    amos_raw_t z;
  } amos_raw_s;

  typedef struct packed {
    amos_code_t x;
    amos_code_t y;
    amos_code_t z;
  } amos_sample_s;

endpackage

`default_nettype wire

// File: core/amos_core.sv
// mode control, sample scaling and bus pin conditioning of the accelerometer
`timescale 1ns/1ps
`default_nettype none
`include "amos_cfg.svh"

module amos_core
  import amos_pkg::*;
(
  // clock, reset, enable
  input  wire logic                    i_core_clk,
  input  wire logic                    i_rst_n,
  input  wire logic                    i_clk_en,
  // bus pins
  input  wire logic                    i_scl,
  input  wire logic                    i_sda,
  input  wire logic                    i_sda_drive_low,
  output logic                         o_scl_o,
  output logic                         o_scl_oe_n,
  output logic                         o_sda_o,
  output logic                         o_sda_oe_n,
  output logic                         o_scl_filt,
  output logic                         o_sda_filt,
  // control levels
  input  wire logic                    i_run_enable,
  input  wire logic [1:0]              i_range,
  input  wire logic                    i_self_test,
  input  wire logic                    i_sleep_req,
  input  wire logic                    i_wake_req,
  // analog front end
  input  wire logic                    i_raw_valid,
  input  wire amos_raw_s               i_raw,
  input  wire amos_raw_s               i_st_stim,
  // register read port
  input  wire logic                    i_rd_en,
  input  wire logic [`AMOS_ADDR_W-1:0] i_rd_addr,
  output logic [7:0]                   o_rd_data,
  output logic                         o_rd_valid,
  // status
  output amos_mode_e                   o_mode,
  output logic                         o_analog_en,
  output logic                         o_sample_clk_en,
  output logic                         o_data_ready,
  output amos_sample_s                 o_sample
);

  ////////////////////////////////////////////////////////////////////////
  // pin filters: three flip-flops, then a stability counter

  logic [1:0] pin_in;
  logic [1:0] pin_filt;

  assign pin_in = {i_sda, i_scl};

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_pin
      logic [2:0]              sync_reg;
      logic [2:0]              sync_next;
      logic [`AMOS_FILT_W-1:0] cnt_reg;
      logic [`AMOS_FILT_W-1:0] cnt_next;
      logic                    filt_reg;
      logic                    filt_next;

      // only the second and third stages are compared
      always_comb begin
        sync_next = {sync_reg[1:0], pin_in[g]};
        cnt_next  = '0;
        filt_next = filt_reg;
        if (sync_reg[1] == sync_reg[2] && sync_reg[2] != filt_reg) begin
          if (cnt_reg == `AMOS_FILT_W'(`AMOS_SPIKE_CYC)) begin
            filt_next = sync_reg[2]; // outlasted the longest spike
          end else begin
            cnt_next = cnt_reg + `AMOS_FILT_W'(1);
          end
        end
      end

      // idle bus level is high
      always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          sync_reg <= 3'h7;
          cnt_reg  <= '0;
          filt_reg <= 1'b1;
        end else if (i_clk_en) begin
          sync_reg <= sync_next;
          cnt_reg  <= cnt_next;
          filt_reg <= filt_next;
        end
      end

      assign pin_filt[g] = filt_reg;
    end
  endgenerate

  assign o_scl_filt = pin_filt[0];
  assign o_sda_filt = pin_filt[1];

  ////////////////////////////////////////////////////////////////////////
  // pin drivers

  logic sda_oe_n_reg;
  logic sda_oe_n_next;

  // the clock line is never driven, so the low phase is never held
  assign o_scl_o    = 1'b0;
  assign o_scl_oe_n = 1'b1;
  assign o_sda_o    = 1'b0;
  assign o_sda_oe_n = sda_oe_n_reg;

  // open drain: only ever pull low
  always_comb begin
    sda_oe_n_next = ~i_sda_drive_low;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sda_oe_n_reg <= 1'b1;
    end else if (i_clk_en) begin
      sda_oe_n_reg <= sda_oe_n_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // operating mode

  amos_mode_e mode_reg;
  amos_mode_e mode_next;
  logic       entering_active;

  // sleep and wake are reachable only with run-enable set
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      AMOS_STANDBY: begin
        if (i_run_enable) begin
          mode_next = AMOS_WAKE; // active mode
        end
      end
      AMOS_WAKE: begin
        if (!i_run_enable) begin
          mode_next = AMOS_STANDBY;
        end else if (i_sleep_req) begin
          mode_next = AMOS_SLEEP;
        end
      end
      AMOS_SLEEP: begin
        if (!i_run_enable) begin
          mode_next = AMOS_STANDBY;
        end else if (i_wake_req) begin
          mode_next = AMOS_WAKE;
        end
      end
      default: begin
        mode_next = AMOS_STANDBY;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_reg <= AMOS_STANDBY;
    end else if (i_clk_en) begin
      mode_reg <= mode_next;
    end
  end

  assign entering_active = (mode_reg == AMOS_STANDBY) && i_run_enable;
  assign o_mode          = mode_reg;
  // analog and sample clock follow the registered mode
  assign o_analog_en     = (mode_reg != AMOS_STANDBY);
  assign o_sample_clk_en = (mode_reg != AMOS_STANDBY);

  ////////////////////////////////////////////////////////////////////////
  // scaling: input is in 1/256 g, shifted down for wider ranges

  function automatic amos_code_t scale_axis(
    input amos_raw_t  raw,
    input amos_raw_t  stim,
    input logic       st_on,
    input logic [1:0] shift
  );
    logic signed [`AMOS_RAW_W:0] sum;
    logic signed [`AMOS_RAW_W:0] shifted;
    sum = {raw[`AMOS_RAW_W-1], raw};
    // stimulus joins before scaling so its shift tracks the range
    if (st_on) begin
      sum = sum + {stim[`AMOS_RAW_W-1], stim};
    end
    shifted = sum >>> shift; // 256/128/64 counts per g
    // zero g stays code zero; saturate at the signed ends
    if (shifted > $signed({{(`AMOS_RAW_W-`AMOS_OUT_W+1){1'b0}},
                           `AMOS_OUT_MAX})) begin
      scale_axis = `AMOS_OUT_MAX;
    end else if (shifted < $signed({{(`AMOS_RAW_W-`AMOS_OUT_W+1){1'b1}},
                                   `AMOS_OUT_MIN})) begin
      scale_axis = `AMOS_OUT_MIN;
    end else begin
      scale_axis = shifted[`AMOS_OUT_W-1:0];
    end
  endfunction

  logic [1:0] range_shift;

  always_comb begin
    case (i_range)
      `AMOS_RANGE_4G: range_shift = `AMOS_SHIFT_4G;
      `AMOS_RANGE_8G: range_shift = `AMOS_SHIFT_8G;
      default:        range_shift = `AMOS_SHIFT_2G;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // sample registers and data-ready flag

  amos_sample_s sample_reg;
  amos_sample_s sample_next;
  logic         ready_reg;
  logic         ready_next;
  logic         take;
  logic         ready_clr;

  // standby ignores the front end; old values stay readable
  assign take      = i_raw_valid && (mode_reg != AMOS_STANDBY);
  assign ready_clr = i_rd_en && (i_rd_addr == `AMOS_ADDR_X_HI);

  always_comb begin
    sample_next = sample_reg;
    ready_next  = ready_reg;
    if (ready_clr) begin
      ready_next = 1'b0;
    end
    if (entering_active) begin
      ready_next = 1'b0; // subset back to reset on entering active
    end
    if (take) begin
      sample_next.x = scale_axis(i_raw.x, i_st_stim.x, i_self_test,
                                 range_shift);
      sample_next.y = scale_axis(i_raw.y, i_st_stim.y, i_self_test,
                                 range_shift);
      sample_next.z = scale_axis(i_raw.z, i_st_stim.z, i_self_test,
                                 range_shift);
      ready_next    = 1'b1; // a new sample beats a same-cycle clear
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sample_reg <= '0;
      ready_reg  <= 1'b0;
    end else if (i_clk_en) begin
      sample_reg <= sample_next;
      ready_reg  <= ready_next;
    end
  end

  assign o_sample     = sample_reg;
  assign o_data_ready = ready_reg;

  ////////////////////////////////////////////////////////////////////////
  // read port, served in every mode

  logic [7:0] rd_data_reg;
  logic [7:0] rd_data_next;
  logic       rd_valid_reg;
  logic       rd_valid_next;

  // high byte holds bits 9:2, low byte bits 1:0 left aligned
  always_comb begin
    rd_valid_next = i_rd_en; // no mode gating here
    rd_data_next  = rd_data_reg;
    if (i_rd_en) begin
      case (i_rd_addr)
        `AMOS_ADDR_X_HI: rd_data_next = sample_reg.x[9:2];
        `AMOS_ADDR_X_LO: rd_data_next = {sample_reg.x[1:0], 6'h00};
        `AMOS_ADDR_Y_HI: rd_data_next = sample_reg.y[9:2];
        `AMOS_ADDR_Y_LO: rd_data_next = {sample_reg.y[1:0], 6'h00};
        `AMOS_ADDR_Z_HI: rd_data_next = sample_reg.z[9:2];
        `AMOS_ADDR_Z_LO: rd_data_next = {sample_reg.z[1:0], 6'h00};
        default:         rd_data_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_data_reg  <= 8'h00;
      rd_valid_reg <= 1'b0;
    end else if (i_clk_en) begin
      rd_data_reg  <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
    end
  end

  assign o_rd_data  = rd_data_reg;
  assign o_rd_valid = rd_valid_reg;

endmodule

`default_nettype wire

// File: testbench/amos_core_sva.sv
// assertions on the mode, sample, pin and read ports of amos_core
`timescale 1ns/1ps
`default_nettype none
`include "amos_cfg.svh"
module amos_core_sva
  import amos_pkg::*;
(
  // clock, reset and requests
  input wire logic                    i_core_clk,
  input wire logic                    i_rst_n,
  input wire logic                    i_clk_en,
  input wire logic                    i_sda,
  input wire logic                    i_run_enable,
  input wire logic                    i_raw_valid,
  input wire logic                    i_rd_en,
  input wire logic [`AMOS_ADDR_W-1:0] i_rd_addr,
  // answers
  input wire logic                    o_scl_oe_n,
  input wire logic                    o_sda_filt,
  input wire logic [7:0]              o_rd_data,
  input wire logic                    o_rd_valid,
  input wire amos_mode_e              o_mode,
  input wire logic                    o_analog_en,
  input wire logic                    o_sample_clk_en,
  input wire logic                    o_data_ready,
  input wire amos_sample_s            o_sample
);
  logic [9:0] x_prev_reg;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////////////////////////////////////////
  // x code one edge back, since read data lags the request by one edge
  always_ff @(posedge i_core_clk) x_prev_reg <= o_sample.x;
  // leaving standby, and a read with no sample racing it
  sequence s_go;
    o_mode == AMOS_STANDBY && i_run_enable && i_clk_en;
  endsequence
  sequence s_rd;
    i_rd_en && i_clk_en && !i_raw_valid;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  AST_NO_STRETCH: assert property (o_scl_oe_n)
    else $error("clock line driven");
  AST_SPIKE: assert property ($fell(o_sda_filt) |->
    $past(i_sda, 4) == 1'b0 && $past(i_sda, 8) == 1'b0)
    else $error("short low level passed the filter");
  AST_STBY_OFF: assert property (o_mode == AMOS_STANDBY |->
    !o_analog_en && !o_sample_clk_en) else $error("sampling on in standby");
  AST_ACT_ON: assert property (o_mode != AMOS_STANDBY |->
    o_analog_en && o_sample_clk_en) else $error("sampling off when active");
  AST_ENTRY: assert property (s_go |=>
    o_mode == AMOS_WAKE && !o_data_ready) else $error("bad active entry");
  AST_RUN_OFF: assert property (!i_run_enable && i_clk_en |=>
    o_mode == AMOS_STANDBY) else $error("not standby");
  AST_SLEEP_SRC: assert property (o_mode == AMOS_SLEEP |->
    $past(o_mode) != AMOS_STANDBY) else $error("sleep from standby");
  AST_HOLD: assert property (!(i_raw_valid && o_mode != AMOS_STANDBY)
    |=> $stable(o_sample)) else $error("sample changed untaken");
  AST_RD_ANS: assert property (i_rd_en && i_clk_en |=> o_rd_valid)
    else $error("read not answered");
  AST_RD_HI: assert property (s_rd ##0 i_rd_addr == 3'h0 |=>
    o_rd_data == x_prev_reg[9:2]) else $error("high byte wrong");
  AST_RD_LO: assert property (s_rd ##0 i_rd_addr == 3'h1 |=>
    o_rd_data == {x_prev_reg[1:0], 6'h00}) else $error("low byte wrong");
endmodule
`default_nettype wire

// File: testbench/amos_host_model.sv
// behavioural bus host: sets modes, reads samples, disturbs bus pins
`timescale 1ns/1ps
`default_nettype none
module amos_host_model (
  // clock and device answers
  input  wire logic i_core_clk,
  input  wire logic i_scl_oe_n,
  input  wire logic i_sda_oe_n,
  input  wire logic i_rd_valid,
  // requests and pin levels toward the device
  output logic       o_run_enable,
  output logic [1:0] o_range,
  output logic       o_self_test,
  output logic       o_rd_en,
  output logic [2:0] o_rd_addr,
  output logic       o_scl,
  output logic       o_sda
);
  logic scl_low;
  logic sda_low;
  // both lines are pulled up; either party may pull low
  assign o_scl = !(scl_low || !i_scl_oe_n);
  assign o_sda = !(sda_low || !i_sda_oe_n);
  initial begin
    {o_run_enable, o_range, o_self_test, o_rd_en, scl_low, sda_low} = '0;
    o_rd_addr = 3'h7;
  end
  // called at a falling edge; level changes at once
  task automatic line(input logic on_sda, input logic low);
    if (on_sda) sda_low = low;
    else scl_low = low;
  endtask
  task automatic run(input logic on);
    o_run_enable = on;
  endtask
  // config only changes in standby, half a cycle after its entry and a cycle before run-enable returns
  task automatic set_cfg(input logic [1:0] rng, input logic st);
    o_run_enable = 1'b0;
    @(negedge i_core_clk);
    o_range = rng;
    o_self_test = st;
    @(negedge i_core_clk);
    o_run_enable = 1'b1;
  endtask
  // one read pulse; address scrambled once released
  task automatic rd(input logic [2:0] a, output logic ok);
    @(negedge i_core_clk);
    o_rd_en = 1'b1;
    o_rd_addr = a;
    @(negedge i_core_clk);
    o_rd_en = 1'b0;
    o_rd_addr = ~a;
    ok = i_rd_valid;
  endtask
endmodule
`default_nettype wire

// File: testbench/accel_mode_and_output_scaling_tb.sv
// self-checking bench for mode control and output scaling
`timescale 1ns/1ps
`default_nettype none
`include "amos_cfg.svh"
module accel_mode_and_output_scaling_tb
  import amos_pkg::*;
;
  logic clk, rst_n, drive_low, sleep_req, wake_req, raw_valid;
  logic run_en, st, rd_en, scl, sda, scl_oe_n, sda_oe_n, scl_filt, sda_filt;
  logic rd_valid, analog_en, sclk_en, dready, scl_o, sda_o;
  logic [1:0] rng;
  logic [2:0] rd_addr;
  logic [7:0] rd_data;
  amos_raw_s raw, stim;
  amos_mode_e mode;
  amos_sample_s sample;
  int failures, checks;
  ////////////////////////////////////////////////////////////////////////////
  amos_core dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_clk_en(1'b1),
    .i_scl(scl), .i_sda(sda), .i_sda_drive_low(drive_low), .o_scl_o(scl_o),
    .o_scl_oe_n(scl_oe_n), .o_sda_o(sda_o), .o_sda_oe_n(sda_oe_n),
    .o_scl_filt(scl_filt), .o_sda_filt(sda_filt), .i_run_enable(run_en),
    .i_range(rng), .i_self_test(st), .i_sleep_req(sleep_req),
    .i_wake_req(wake_req), .i_raw_valid(raw_valid), .i_raw(raw),
    .i_st_stim(stim), .i_rd_en(rd_en), .i_rd_addr(rd_addr),
    .o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_mode(mode),
    .o_analog_en(analog_en), .o_sample_clk_en(sclk_en),
    .o_data_ready(dready), .o_sample(sample));
  amos_host_model host (.i_core_clk(clk), .i_scl_oe_n(scl_oe_n),
    .i_sda_oe_n(sda_oe_n), .i_rd_valid(rd_valid), .o_run_enable(run_en),
    .o_range(rng), .o_self_test(st), .o_rd_en(rd_en), .o_rd_addr(rd_addr),
    .o_scl(scl), .o_sda(sda));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic nclk(input int n);
    repeat (n) @(negedge clk);
  endtask
  // expected code: shift per range, then clamp to ten bits
  function automatic logic [9:0] code(input int v, input logic [1:0] r);
    int s;
    s = (r == 2'h1) ? 1 : (r == 2'h2) ? 2 : 0;
    v = v >>> s;
    if (v > 511) v = 511;
    if (v < -512) v = -512;
    return v[9:0];
  endfunction
  task automatic smp(input int x, input int y, input int z);
    @(negedge clk);
    raw_valid = 1'b1;
    raw = {x[13:0], y[13:0], z[13:0]};
    @(negedge clk);
    raw_valid = 1'b0;
    raw = ~raw;
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    logic ok;
    host.rd(a, ok);
    chk(ok, 1'b1);
    chk(rd_data, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_pins;
    drive_low = 1'b1;
    nclk(2);
    chk(sda, 1'b0);
    chk({scl_o, sda_o}, 2'h0);
    drive_low = 1'b0;
    nclk(12);
    host.line(1'b1, 1'b1);
    nclk(5);
    host.line(1'b1, 1'b0);
    host.line(1'b0, 1'b1);
    nclk(5);
    host.line(1'b0, 1'b0);
    nclk(12);
    chk({sda_filt, scl_filt, scl_oe_n}, 3'h7);
    host.line(1'b1, 1'b1);
    nclk(12);
    chk(sda_filt, 1'b0);
    host.line(1'b1, 1'b0);
    nclk(12);
    chk(sda_filt, 1'b1);
  endtask
  task automatic t_modes;
    host.run(1'b1);
    nclk(1);
    chk({mode, analog_en, sclk_en}, {AMOS_WAKE, 2'h3});
    sleep_req = 1'b1;
    nclk(1);
    sleep_req = 1'b0;
    chk(mode, AMOS_SLEEP);
    wake_req = 1'b1;
    nclk(1);
    wake_req = 1'b0;
    chk(mode, AMOS_WAKE);
    sleep_req = 1'b1;
    host.run(1'b0);
    nclk(2);
    sleep_req = 1'b0;
    chk({mode, analog_en, sclk_en}, {AMOS_STANDBY, 2'h0});
  endtask
  // every range and self-test setting; z saturates, y reads zero at rest with self-test off
  task automatic t_scale;
    logic [9:0] c [3];
    for (int r = 0; r < 4; r++) begin
      for (int s = 0; s < 2; s++) begin
        host.set_cfg(r[1:0], s[0]);
        smp(256, 0, 8191);
        c[0] = code(256 + 64 * s, r[1:0]);
        c[1] = code(-32 * s, r[1:0]);
        c[2] = 10'h1ff;
        chk(sample.x, c[0]);
        chk(sample.y, c[1]);
        chk(sample.z, c[2]);
        for (int a = 0; a < 8; a++) begin
          rd_chk(a[2:0], a > 5 ? 8'h00 : a[0] ? {c[a / 2][1:0], 6'h00}
                 : c[a / 2][9:2]);
        end
      end
    end
  endtask
  task automatic t_standby;
    host.set_cfg(2'h0, 1'b0);
    smp(100, 0, 0);
    host.run(1'b0);
    smp(200, 0, 0);
    chk(sample.x, 10'd100);
    chk(dready, 1'b1);
    rd_chk(3'h2, 8'h00);
    host.run(1'b1);
    nclk(1);
    chk(sample.x, 10'd100);
    chk(dready, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    results;
  end
  initial begin
    failures = 0;
    checks = 0;
    {rst_n, drive_low, sleep_req, wake_req, raw_valid} = '0;
    raw = '0;
    stim = {14'd64, -14'sd32, 14'd0};
    nclk(4);
    rst_n = 1'b1;
    t_pins;
    t_modes;
    t_scale;
    t_standby;
    results;
  end
endmodule
// checker rides on every core instance
bind amos_core amos_core_sva u_sva (.i_core_clk, .i_rst_n, .i_clk_en,
  .i_sda, .i_run_enable, .i_raw_valid, .i_rd_en, .i_rd_addr, .o_scl_oe_n,
  .o_sda_filt, .o_rd_data, .o_rd_valid, .o_mode, .o_analog_en,
  .o_sample_clk_en, .o_data_ready, .o_sample);
`default_nettype wire
